// [rtl/rx_cell_filter_monitor.sv]
// Functional notes
// - threshold 00/01/10/11 needs 1/2/4/8 good-header cells before correction resumes
// - with level select one, cell available falls only when fifo empty
// - with level select zero, cell available falls at four words left
// - loss state declared after 4 ms of continuous out of delineation
// - loss state removed after 4 ms of continuous delineation
// - drop bit one: no fifo writes while in loss state
// - drop bit zero: write whenever in delineation, regardless of loss state
// - overrun interrupts only when overrun enable is one
// - header errors interrupt only when header error enable is one
// - loss entry and exit interrupt when loss enable is one
// - delineation change interrupts when change enable is one
// - flow ctrl vs octet1 bits 1-4, pti vs octet4 bits 5-7, clp octet4 bit 8
// - mask bit one compares pattern bit, zero ignores it
// - matching cells dropped only while pass bit is zero
// - a match also needs all-zero vpi and vci
// - 12-bit correctable error snapshot split over low and high registers
// - 12-bit uncorrectable error snapshot split over low and high registers
// - write to counter space transfers counts; reader waits 7 us
// - write to global address zero also transfers counts
// - sticky status bits clear when the status register is read
// - change status set on presync to sync and sync to hunt
// - loss status set on entering and leaving loss state
module rx_cell_filter_monitor #(
  parameter int LOSS_CYCLES = rx_cell_monitor_pkg::LOSS_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_cell_monitor_pkg::ADDR_W-1:0] paddr,
  input wire logic [rx_cell_monitor_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [rx_cell_monitor_pkg::DATA_W-1:0] prdata,
  // delineation and header check events
  input rx_cell_monitor_pkg::delin_state_t delin_state,
  input wire logic corr_err_event,
  input wire logic uncorr_err_event,
  input wire logic overrun_event,
  input wire logic underrun_event,
  // receive fifo level
  input wire logic fifo_empty,
  input wire logic [rx_cell_monitor_pkg::FIFO_CNT_W-1:0] fifo_word_count,
  // cell header, valid for one cycle per cell
  input wire logic cell_valid,
  input wire logic [31:0] cell_header,
  // outputs
  output logic cell_write,
  output logic cell_available_out,
  output logic delineation_loss_state,
  output logic [rx_cell_monitor_pkg::RECOV_W-1:0] recovery_cells_needed,
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] irq_en;
    logic [7:0] pattern;
    logic [7:0] mask;
    logic [rx_cell_monitor_pkg::ST_W-1:0] status;
    logic loss;
    logic [rx_cell_monitor_pkg::LOSS_TIMER_W-1:0] loss_timer;
    rx_cell_monitor_pkg::delin_state_t prev_delin;
    logic [rx_cell_monitor_pkg::CNT_W-1:0] corr_cnt;
    logic [rx_cell_monitor_pkg::CNT_W-1:0] uncorr_cnt;
    logic [rx_cell_monitor_pkg::CNT_W-1:0] corr_snap;
    logic [rx_cell_monitor_pkg::CNT_W-1:0] uncorr_snap;
    logic ready;
    logic slverr;
    logic [rx_cell_monitor_pkg::DATA_W-1:0] rdata;
    logic cell_wr;
    logic avail;
    logic [rx_cell_monitor_pkg::RECOV_W-1:0] recov;
    logic irq;
  } state_t;

  state_t state_q;
  state_t state_d;

  localparam int ADDR_TOP = rx_cell_monitor_pkg::ADDR_W - 1;
  localparam logic [rx_cell_monitor_pkg::LOSS_TIMER_W-1:0] LOSS_TIMER_LAST =
    rx_cell_monitor_pkg::LOSS_TIMER_W'(LOSS_CYCLES - 1);

  function automatic logic [rx_cell_monitor_pkg::CNT_W-1:0] sat_inc(
    input logic [rx_cell_monitor_pkg::CNT_W-1:0] cnt,
    input logic ev
  );
    // saturating, so a missed poll reads as full scale, not a small wrapped number
    if (ev && (cnt != '1))
      sat_inc = cnt + 1'b1;
    else
      sat_inc = cnt;
  endfunction : sat_inc

  function automatic logic [rx_cell_monitor_pkg::RECOV_W-1:0] recov_decode(
    input logic [rx_cell_monitor_pkg::THRESH_W-1:0] thr
  );
    recov_decode = rx_cell_monitor_pkg::RECOV_W'(1) << thr;
  endfunction : recov_decode

  function automatic logic hdr_filtered(
    input logic [31:0] hdr,
    input logic [7:0] pat,
    input logic [7:0] msk
  );
    logic [7:0] fields;
    logic zero_ids;
    fields = {hdr[31:28], hdr[3:0]};
    zero_ids = (hdr[27:4] == '0);
    hdr_filtered = zero_ids && (((fields ^ pat) & msk) == '0);
  endfunction : hdr_filtered

  logic [rx_cell_monitor_pkg::IDX_W-1:0] idx;
  logic commit;
  logic wr_commit;
  logic rd_commit;
  logic mapped;
  logic xfer;
  logic out_delin;
  logic filtered;
  logic [rx_cell_monitor_pkg::ST_W-1:0] st_set;
  logic [7:0] en_d;
  logic [rx_cell_monitor_pkg::DATA_W-1:0] rd_val;

  assign idx = paddr[rx_cell_monitor_pkg::IDX_W+1:2];
  // one wait state, so the read value and the side effects come from the same edge
  assign commit = psel && penable && !state_q.ready;
  assign wr_commit = commit && pwrite && mapped;
  assign rd_commit = commit && !pwrite && mapped;
  assign out_delin = (delin_state != rx_cell_monitor_pkg::DELIN_SYNC);

  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) && (paddr[ADDR_TOP:rx_cell_monitor_pkg::IDX_W+2] == '0) &&
      ((idx == rx_cell_monitor_pkg::IDX_GLOBAL_LOAD) ||
       ((idx >= rx_cell_monitor_pkg::IDX_RX_CTRL) && (idx <= rx_cell_monitor_pkg::IDX_CNT_SPACE_LAST)));
  end

  // any counter space write, or the global load address, moves counts
  assign xfer = wr_commit && ((idx == rx_cell_monitor_pkg::IDX_GLOBAL_LOAD) ||
    ((idx >= rx_cell_monitor_pkg::IDX_CORR_LOW) && (idx <= rx_cell_monitor_pkg::IDX_CNT_SPACE_LAST)));

  always_comb
  begin
    rd_val = '0;
    unique case (idx)
      rx_cell_monitor_pkg::IDX_RX_CTRL: rd_val[7:0] = state_q.ctrl;
      rx_cell_monitor_pkg::IDX_RX_STATUS: rd_val[7:0] = {out_delin, state_q.loss, state_q.status};
      rx_cell_monitor_pkg::IDX_IRQ_ENABLE_CTRL: rd_val[7:0] = state_q.irq_en;
      rx_cell_monitor_pkg::IDX_MATCH_PATTERN: rd_val[7:0] = state_q.pattern;
      rx_cell_monitor_pkg::IDX_MATCH_MASK: rd_val[7:0] = state_q.mask;
      rx_cell_monitor_pkg::IDX_CORR_LOW: rd_val[7:0] = state_q.corr_snap[7:0];
      rx_cell_monitor_pkg::IDX_CORR_HIGH: rd_val[3:0] = state_q.corr_snap[11:8];
      rx_cell_monitor_pkg::IDX_UNCORR_LOW: rd_val[7:0] = state_q.uncorr_snap[7:0];
      rx_cell_monitor_pkg::IDX_UNCORR_HIGH: rd_val[3:0] = state_q.uncorr_snap[11:8];
      default: rd_val = '0;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    st_set = '0;

    // bus
    state_d.ready = commit;
    state_d.slverr = commit && !mapped;
    state_d.rdata = (commit && !pwrite && mapped) ? rd_val : '0;
    if (wr_commit)
    begin
      unique case (idx)
        rx_cell_monitor_pkg::IDX_RX_CTRL: state_d.ctrl = pwdata[7:0];
        rx_cell_monitor_pkg::IDX_IRQ_ENABLE_CTRL: state_d.irq_en = pwdata[7:0];
        rx_cell_monitor_pkg::IDX_MATCH_PATTERN: state_d.pattern = pwdata[7:0];
        rx_cell_monitor_pkg::IDX_MATCH_MASK: state_d.mask = pwdata[7:0];
        default: state_d.ctrl = state_q.ctrl;
      endcase
    end

    // loss of delineation timing
    if (out_delin != state_q.loss)
    begin
      if (state_q.loss_timer == LOSS_TIMER_LAST)
      begin
        state_d.loss = out_delin;
        state_d.loss_timer = '0;
        st_set[rx_cell_monitor_pkg::ST_DELIN_LOSS] = 1'b1;
      end
      else
        state_d.loss_timer = state_q.loss_timer + 1'b1;
    end
    else
      state_d.loss_timer = '0; // any interruption restarts the persistence count

    // delineation change
    state_d.prev_delin = delin_state;
    if (((state_q.prev_delin == rx_cell_monitor_pkg::DELIN_PRESYNC) &&
         (delin_state == rx_cell_monitor_pkg::DELIN_SYNC)) ||
        ((state_q.prev_delin == rx_cell_monitor_pkg::DELIN_SYNC) &&
         (delin_state == rx_cell_monitor_pkg::DELIN_HUNT)))
      st_set[rx_cell_monitor_pkg::ST_DELIN_CHANGE] = 1'b1;
    st_set[rx_cell_monitor_pkg::ST_CORR] = corr_err_event;
    st_set[rx_cell_monitor_pkg::ST_UNCORR] = uncorr_err_event;
    st_set[rx_cell_monitor_pkg::ST_OVERRUN] = overrun_event;
    st_set[rx_cell_monitor_pkg::ST_UNDERRUN] = underrun_event;

    // read clears, a same-cycle event survives
    if (rd_commit && (idx == rx_cell_monitor_pkg::IDX_RX_STATUS))
      state_d.status = st_set;
    else
      state_d.status = state_q.status | st_set;

    // counters
    if (xfer)
    begin
      state_d.corr_snap = state_q.corr_cnt;
      state_d.uncorr_snap = state_q.uncorr_cnt;
      state_d.corr_cnt = sat_inc('0, corr_err_event);
      state_d.uncorr_cnt = sat_inc('0, uncorr_err_event);
    end
    else
    begin
      state_d.corr_cnt = sat_inc(state_q.corr_cnt, corr_err_event);
      state_d.uncorr_cnt = sat_inc(state_q.uncorr_cnt, uncorr_err_event);
    end

    // interrupt from the next status and enables
    en_d = state_d.irq_en;
    state_d.irq =
      (state_d.status[rx_cell_monitor_pkg::ST_DELIN_CHANGE] && en_d[rx_cell_monitor_pkg::DELIN_CHANGE_EN_BIT]) ||
      (state_d.status[rx_cell_monitor_pkg::ST_DELIN_LOSS] && en_d[rx_cell_monitor_pkg::DELIN_LOSS_EN_BIT]) ||
      ((state_d.status[rx_cell_monitor_pkg::ST_CORR] || state_d.status[rx_cell_monitor_pkg::ST_UNCORR]) &&
       en_d[rx_cell_monitor_pkg::HDR_ERR_EN_BIT]) ||
      (state_d.status[rx_cell_monitor_pkg::ST_OVERRUN] && en_d[rx_cell_monitor_pkg::OVERRUN_EN_BIT]);

    // cell write gating
    state_d.cell_wr = cell_valid && !out_delin && !filtered &&
      !(state_q.irq_en[rx_cell_monitor_pkg::DROP_LOSS_BIT] && state_q.loss);

    // cell available level
    if (state_q.irq_en[rx_cell_monitor_pkg::AVAIL_LEVEL_BIT])
      state_d.avail = !fifo_empty;
    else
      state_d.avail = (fifo_word_count > rx_cell_monitor_pkg::NEAR_EMPTY_WORDS);

    state_d.recov = recov_decode(state_q.irq_en[rx_cell_monitor_pkg::THRESH_LSB +: rx_cell_monitor_pkg::THRESH_W]);
  end

  // the idle filter is bypassed entirely when pass is set
  assign filtered = !state_q.ctrl[rx_cell_monitor_pkg::PASS_BIT] &&
    hdr_filtered(cell_header, state_q.pattern, state_q.mask);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= '0;
      state_q.ctrl <= rx_cell_monitor_pkg::RX_CTRL_RST;
      state_q.irq_en <= rx_cell_monitor_pkg::IRQ_ENABLE_CTRL_RST;
      state_q.pattern <= rx_cell_monitor_pkg::MATCH_RST;
      state_q.mask <= rx_cell_monitor_pkg::MATCH_RST;
      state_q.prev_delin <= rx_cell_monitor_pkg::DELIN_HUNT;
      state_q.recov <= rx_cell_monitor_pkg::RECOV_W'(1);
    end
    else
      state_q <= state_d;
  end

  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign prdata = state_q.rdata;
  assign cell_write = state_q.cell_wr;
  assign cell_available_out = state_q.avail;
  assign delineation_loss_state = state_q.loss;
  assign recovery_cells_needed = state_q.recov;
  assign irq = state_q.irq;

  // helper: cycles that the loss state has disagreed with the delineation level
  logic [rx_cell_monitor_pkg::LOSS_TIMER_W:0] disagree_q;
  always_ff @(posedge clk)
  begin
    if (srst)
      disagree_q <= '0;
    else if (out_delin != state_q.loss)
      disagree_q <= disagree_q + 1'b1;
    else
      disagree_q <= '0;
  end

  property p_loss_persist;
    @(posedge clk) disable iff (srst)
    $changed(state_q.loss) |-> ($past(disagree_q) == (rx_cell_monitor_pkg::LOSS_TIMER_W + 1)'(LOSS_CYCLES - 1));
  endproperty
  a_loss_persist: assert property (p_loss_persist) else $error("loss state changed at wrong persistence");

  property p_loss_follows;
    @(posedge clk) disable iff (srst)
    $changed(state_q.loss) |-> (state_q.loss == $past(out_delin));
  endproperty
  a_loss_follows: assert property (p_loss_follows) else $error("loss state moved against delineation");

  property p_avail_empty;
    @(posedge clk) disable iff (srst)
    state_q.irq_en[rx_cell_monitor_pkg::AVAIL_LEVEL_BIT] && !fifo_empty |=> cell_available_out;
  endproperty
  a_avail_empty: assert property (p_avail_empty) else $error("cell available dropped before empty");

  property p_avail_near;
    @(posedge clk) disable iff (srst)
    !state_q.irq_en[rx_cell_monitor_pkg::AVAIL_LEVEL_BIT] && (fifo_word_count <= rx_cell_monitor_pkg::NEAR_EMPTY_WORDS)
      |=> !cell_available_out;
  endproperty
  a_avail_near: assert property (p_avail_near) else $error("cell available high at near empty");

  property p_drop_loss;
    @(posedge clk) disable iff (srst)
    state_q.irq_en[rx_cell_monitor_pkg::DROP_LOSS_BIT] && state_q.loss |=> !cell_write;
  endproperty
  a_drop_loss: assert property (p_drop_loss) else $error("cell written during loss state");

  property p_pass_write;
    @(posedge clk) disable iff (srst)
    cell_valid && !out_delin && state_q.ctrl[rx_cell_monitor_pkg::PASS_BIT] &&
      !state_q.irq_en[rx_cell_monitor_pkg::DROP_LOSS_BIT] |=> cell_write;
  endproperty
  a_pass_write: assert property (p_pass_write) else $error("cell not written in delineation");

  property p_overrun_irq;
    @(posedge clk) disable iff (srst)
    overrun_event && state_q.irq_en[rx_cell_monitor_pkg::OVERRUN_EN_BIT] && !wr_commit |=> irq;
  endproperty
  a_overrun_irq: assert property (p_overrun_irq) else $error("overrun did not interrupt");

  property p_hdr_irq;
    @(posedge clk) disable iff (srst)
    (corr_err_event || uncorr_err_event) && state_q.irq_en[rx_cell_monitor_pkg::HDR_ERR_EN_BIT] && !wr_commit |=> irq;
  endproperty
  a_hdr_irq: assert property (p_hdr_irq) else $error("header error did not interrupt");

  property p_no_en_no_irq;
    @(posedge clk) disable iff (srst)
    (state_q.irq_en[7:4] == 4'h0) && !wr_commit |=> !irq;
  endproperty
  a_no_en_no_irq: assert property (p_no_en_no_irq) else $error("interrupt with all enables off");

  property p_xfer_snap;
    @(posedge clk) disable iff (srst)
    xfer |=> (state_q.corr_snap == $past(state_q.corr_cnt)) && (state_q.uncorr_cnt <= 12'h001);
  endproperty
  a_xfer_snap: assert property (p_xfer_snap) else $error("counter transfer wrong");

  property p_status_clear;
    @(posedge clk) disable iff (srst)
    rd_commit && (idx == rx_cell_monitor_pkg::IDX_RX_STATUS) && !overrun_event |=>
      !state_q.status[rx_cell_monitor_pkg::ST_OVERRUN];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

endmodule : rx_cell_filter_monitor

// [rtl/rx_cell_monitor_pkg.sv]
package rx_cell_monitor_pkg;

  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LOSS_TIME_MS = 4;
  // least time, so round up to whole cycles
  localparam int LOSS_CYCLES_DFLT = (LOSS_TIME_MS * CLK_HZ + 999) / 1000;
  localparam int LOSS_TIMER_W = 16;
  localparam int SETTLE_TIME_US = 7;

  // bus
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_GLOBAL_LOAD = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RX_CTRL = 8'h50;
  localparam logic [IDX_W-1:0] IDX_RX_STATUS = 8'h51;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE_CTRL = 8'h52;
  localparam logic [IDX_W-1:0] IDX_MATCH_PATTERN = 8'h53;
  localparam logic [IDX_W-1:0] IDX_MATCH_MASK = 8'h54;
  localparam logic [IDX_W-1:0] IDX_CORR_LOW = 8'h55;
  localparam logic [IDX_W-1:0] IDX_CORR_HIGH = 8'h56;
  localparam logic [IDX_W-1:0] IDX_UNCORR_LOW = 8'h57;
  localparam logic [IDX_W-1:0] IDX_UNCORR_HIGH = 8'h58;
  localparam logic [IDX_W-1:0] IDX_CNT_SPACE_LAST = 8'h5b;

  // reset values
  localparam logic [7:0] RX_CTRL_RST = 8'h84;
  localparam logic [7:0] IRQ_ENABLE_CTRL_RST = 8'h04;
  localparam logic [7:0] MATCH_RST = 8'h00;

  // control register field
  localparam int PASS_BIT = 5;
  // interrupt enable/control fields
  localparam int DELIN_CHANGE_EN_BIT = 7;
  localparam int DELIN_LOSS_EN_BIT = 6;
  localparam int HDR_ERR_EN_BIT = 5;
  localparam int OVERRUN_EN_BIT = 4;
  localparam int DROP_LOSS_BIT = 3;
  localparam int AVAIL_LEVEL_BIT = 2;
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 2;

  // status register: two live levels on top, six sticky bits below
  localparam int OUT_DELIN_LEVEL_BIT = 7;
  localparam int LOSS_LEVEL_BIT = 6;
  localparam int ST_W = 6;
  localparam int ST_DELIN_CHANGE = 5;
  localparam int ST_DELIN_LOSS = 4;
  localparam int ST_CORR = 3;
  localparam int ST_UNCORR = 2;
  localparam int ST_OVERRUN = 1;
  localparam int ST_UNDERRUN = 0;

  // counters and fifo
  localparam int CNT_W = 12;
  localparam int LOW_W = 8;
  localparam int FIFO_CNT_W = 8;
  localparam logic [FIFO_CNT_W-1:0] NEAR_EMPTY_WORDS = 8'h04;
  localparam int RECOV_W = 4;

  typedef enum logic [1:0] {
    DELIN_HUNT,
    DELIN_PRESYNC,
    DELIN_SYNC
  } delin_state_t;

endpackage : rx_cell_monitor_pkg

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOSS = 20;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [rx_cell_monitor_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, cell_header, rd, seed, h, v;
  rx_cell_monitor_pkg::delin_state_t delin_state;
  // event pulses: corr, uncorr, overrun, underrun
  logic [3:0] ev;
  logic fifo_empty, cell_valid, cell_write, cell_available_out, delineation_loss_state, irq, loss_m, m;
  logic [7:0] fifo_word_count, st_m, en_m, pat, msk;
  logic [rx_cell_monitor_pkg::RECOV_W-1:0] recovery_cells_needed;
  int bad_count, num_checks;

  rx_cell_filter_monitor #(.LOSS_CYCLES(LOSS)) uut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .delin_state(delin_state),
    .corr_err_event(ev[3]), .uncorr_err_event(ev[2]), .overrun_event(ev[1]), .underrun_event(ev[0]),
    .fifo_empty(fifo_empty), .fifo_word_count(fifo_word_count), .cell_valid(cell_valid),
    .cell_header(cell_header), .cell_write(cell_write), .cell_available_out(cell_available_out),
    .delineation_loss_state(delineation_loss_state), .recovery_cells_needed(recovery_cells_needed), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic irq_exp();
    return (st_m[5] & en_m[7]) | (st_m[4] & en_m[6]) | ((st_m[3] | st_m[2]) & en_m[5]) | (st_m[1] & en_m[4]);
  endfunction : irq_exp

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_en(input logic [7:0] val);
    en_m = val;
    apb(1'b1, 8'h52, {24'h0, val});
  endtask : set_en

  task automatic rd_status();
    apb(1'b0, 8'h51, 32'h0);
    chk(rd, {24'h0, delin_state != rx_cell_monitor_pkg::DELIN_SYNC, loss_m, st_m[5:0]});
    chk(err, 0);
    st_m = 8'h00;
  endtask : rd_status

  task automatic pulse(input logic [3:0] val);
    @(posedge clk);
    ev <= val;
    @(posedge clk);
    ev <= 4'h0;
    st_m = st_m | {4'h0, val};
  endtask : pulse

  task automatic send_cell(input logic [31:0] hdr, input logic exp);
    @(posedge clk);
    cell_valid <= 1'b1;
    cell_header <= hdr;
    @(posedge clk);
    cell_valid <= 1'b0;
    #1;
    chk(cell_write, exp);
  endtask : send_cell

  // events, then a transfer, then the snapshot read after the settle time
  task automatic count_run(input int nc, input int nu, input logic [7:0] trig);
    int ec, eu;
    for (int i = 0; i < ((nc > nu) ? nc : nu); i++)
    begin
      @(posedge clk);
      ev <= {i < nc, i < nu, 2'b00};
    end
    @(posedge clk);
    ev <= 4'h0;
    apb(1'b1, trig, rnd());
    cyc(70);
    ec = (nc > 4095) ? 4095 : nc;
    eu = (nu > 4095) ? 4095 : nu;
    apb(1'b0, 8'h55, 32'h0);
    chk(rd, ec & 255);
    apb(1'b0, 8'h56, 32'h0);
    chk(rd, ec >> 8);
    apb(1'b0, 8'h57, 32'h0);
    chk(rd, eu & 255);
    apb(1'b0, 8'h58, 32'h0);
    chk(rd, eu >> 8);
  endtask : count_run

  initial
  begin
    seed = 32'd25076;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    delin_state = rx_cell_monitor_pkg::DELIN_SYNC;
    ev = 4'h0;
    fifo_empty = 1'b1;
    fifo_word_count = 8'h00;
    cell_valid = 1'b0;
    cell_header = 32'h0;
    st_m = 8'h00;
    en_m = 8'h04;
    loss_m = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    chk(recovery_cells_needed, 1);
    apb(1'b0, 8'h50, 0);
    chk(rd, 32'h84);
    apb(1'b0, 8'h52, 0);
    chk(rd, 32'h04);
    apb(1'b0, 8'h53, 0);
    chk(rd, 32'h00);
    apb(1'b0, 8'h10, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    count_run(rnd() % 300 + 1, rnd() % 300 + 260, 8'h55);
    count_run(rnd() % 300 + 260, rnd() % 40, 8'h00);
    count_run(4100, 5, 8'h58);
    count_run(0, 0, 8'h59);
    for (int t = 0; t < 4; t++)
    begin
      set_en({6'h01, t[1:0]});
      cyc(2);
      chk(recovery_cells_needed, 1 << t);
    end
    apb(1'b0, 8'h51, 0);
    st_m = 8'h00;
    for (int e = 0; e < 16; e++)
    begin
      set_en({e[3:0], 4'h4});
      v = rnd();
      pulse(v[3:0]);
      cyc(3);
      chk(irq, irq_exp());
      rd_status();
      cyc(2);
      chk(irq, 0);
    end
    for (int lv = 0; lv < 2; lv++)
    begin
      set_en({5'h00, lv[0], 2'b00});
      for (int k = 0; k < 8; k++)
      begin
        v = rnd() % 8;
        @(posedge clk);
        fifo_word_count <= v[7:0];
        fifo_empty <= (v == 0);
        cyc(2);
        chk(cell_available_out, lv ? (v != 0) : (v > 4));
      end
    end
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, 8'h50, p ? 32'ha4 : 32'h84);
      for (int k = 0; k < 16; k++)
      begin
        v = rnd();
        pat = v[7:0];
        msk = v[15:8];
        apb(1'b1, 8'h53, {24'h0, pat});
        apb(1'b1, 8'h54, {24'h0, msk});
        apb(1'b0, 8'h54, 0);
        chk(rd, msk);
        h = rnd();
        if (h[8])
          {h[31:28], h[3:0]} = pat ^ {7'h0, h[10]};
        if (h[9])
          h[27:4] = 24'h0;
        m = ((({h[31:28], h[3:0]} ^ pat) & msk) == 8'h00);
        send_cell(h, !(p == 0 && h[27:4] == 24'h0 && m));
      end
    end
    set_en(8'hcc);
    apb(1'b0, 8'h51, 0);
    st_m = 8'h00;
    @(posedge clk);
    delin_state <= rx_cell_monitor_pkg::DELIN_HUNT;
    st_m = 8'h20;
    cyc(LOSS - 3);
    chk(delineation_loss_state, 0);
    cyc(6);
    chk(delineation_loss_state, 1);
    loss_m = 1'b1;
    st_m = 8'h30;
    chk(irq, irq_exp());
    rd_status();
    send_cell(32'h00010000, 1'b0);
    @(posedge clk);
    delin_state <= rx_cell_monitor_pkg::DELIN_PRESYNC;
    @(posedge clk);
    delin_state <= rx_cell_monitor_pkg::DELIN_SYNC;
    st_m = 8'h20;
    send_cell(32'h00010000, 1'b0);
    set_en(8'hc4);
    send_cell(32'h00010000, 1'b1);
    cyc(LOSS);
    chk(delineation_loss_state, 0);
    loss_m = 1'b0;
    st_m = 8'h30;
    chk(irq, 1);
    rd_status();
    complete_run();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : testbench
